// ### hdl/jsw_job_status.sv
`timescale 1ns/1ns
`include "jsw_regs.svh"
module jsw_job_status #(
    parameter int BUF_COUNT = `JSW_BUF_COUNT
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // job request from the controller program
    input  wire logic        job_req,
    input  wire logic [1:0]  job_kind,
    input  wire logic        job_hi_job_priority_class,
    output logic             job_taken,
    output logic             job_refused,
    // communications processor side
    output logic             cp_job_issue,
    output logic [1:0]       cp_job_kind,
    input  wire logic        cp_ack,
    input  wire logic        cp_ack_error,
    input  wire logic [3:0]  cp_error_id,
    input  wire logic        cp_delete,
    input  wire logic        cp_connected,
    input  wire logic        cp_frame_valid,
    input  wire logic [15:0] cp_frame_len,
    input  wire logic        cp_frame_last,
    output logic             cp_frame_accept,
    output logic             cp_disable_error,
    output logic             cp_recv_handshake,
    // status words visible to the program
    output logic      [15:0] job_status_word,
    output logic      [15:0] job_transfer_length
);
    logic        wr_status;
    logic        wr_control;
    logic [15:0] wr_data;
    logic [5:0]  bufs_free;
    logic        hsk;
    logic        active;
    logic        done_ok;
    logic        done_err;
    logic        xact;
    logic        xdone;
    logic        adone;
    logic        disable_data;
    logic [3:0]  err_num;
    logic [15:0] length;
    logic        first_frame;
    logic        conn_q;
    logic        retrigger;
    logic        data_start;
    logic        frame_fire;
    logic        no_buffer;
    logic [15:0] next_length;
    jsw_pkg::jsw_state_type state;
    jsw_pkg::jsw_job_type   kind;

    jsw_apb_slave i_jsw_apb_slave (
        .pclk        (pclk),
        .presetn     (presetn),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .status_word (job_status_word),
        .length_word (job_transfer_length),
        .bufs_free   (bufs_free),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .wr_status   (wr_status),
        .wr_control  (wr_control),
        .wr_data     (wr_data)
    );

    // a job is taken only while the previous one is no longer active
    assign retrigger = job_req && (state == jsw_pkg::JSW_IDLE) && !active;
    assign no_buffer  = job_hi_job_priority_class && (bufs_free == 6'h00);
    assign data_start = (state == jsw_pkg::JSW_WAIT_ACK) && cp_ack && !cp_ack_error;
    assign frame_fire = (state == jsw_pkg::JSW_XFER) && cp_frame_valid && !disable_data;
    // the word has no room beyond 16 bits, so a longer job wraps
    assign next_length = 16'(length + cp_frame_len);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= jsw_pkg::JSW_IDLE;
            kind  <= jsw_pkg::JSW_JOB_NONE;
        end else begin
            case (state)
                jsw_pkg::JSW_IDLE: begin
                    if (retrigger && !no_buffer) begin
                        state <= jsw_pkg::JSW_WAIT_ACK;
                        kind  <= jsw_pkg::jsw_job_type'(job_kind);
                    end
                end
                jsw_pkg::JSW_WAIT_ACK: begin
                    if (cp_ack && cp_ack_error) begin
                        state <= jsw_pkg::JSW_IDLE;
                    end else if (cp_ack) begin
                        state <= jsw_pkg::JSW_XFER;
                    end
                end
                jsw_pkg::JSW_XFER: begin
                    if (cp_frame_valid && (disable_data || cp_frame_last)) begin
                        state <= jsw_pkg::JSW_IDLE;
                    end
                end
                default: state <= jsw_pkg::JSW_IDLE;
            endcase
        end
    end

    // nibble 1: job status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hsk      <= 1'b0;
            active   <= 1'b0;
            done_ok  <= 1'b0;
            done_err <= 1'b0;
            err_num  <= 4'h0;
            conn_q   <= 1'b0;
        end else begin
            conn_q <= cp_connected;
            hsk    <= !cp_delete;
            if (retrigger && no_buffer) begin
                done_err <= 1'b1;
                done_ok  <= 1'b0;
                err_num  <= `JSW_ERR_NO_BUFFER;
            end else if (retrigger) begin
                active   <= 1'b1;
                done_ok  <= 1'b0;
                done_err <= 1'b0;
            end else if (state == jsw_pkg::JSW_WAIT_ACK && cp_ack) begin
                active <= 1'b0;
                if (cp_ack_error) begin
                    done_err <= 1'b1;
                    err_num  <= cp_error_id;
                end
            end else if (state == jsw_pkg::JSW_XFER && cp_frame_valid && disable_data) begin
                done_err <= 1'b1;
                err_num  <= `JSW_ERR_DISABLED;
            end else if (frame_fire && cp_frame_last) begin
                done_ok <= 1'b1;
            end else if (cp_connected && !conn_q) begin
                done_err <= 1'b1;
                err_num  <= `JSW_ERR_CONNECTED;
            end
        end
    end

    // nibble 2: data management; hardware set wins over software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xact         <= 1'b0;
            xdone        <= 1'b0;
            adone        <= 1'b0;
            disable_data <= 1'b0;
        end else begin
            if (wr_status) begin
                disable_data <= wr_data[`JSW_BIT_DISABLE];
            end
            if (data_start) begin
                xact <= 1'b1;
            end else if (state == jsw_pkg::JSW_XFER && cp_frame_valid &&
                         (cp_frame_last || disable_data)) begin
                xact <= 1'b0;
            end
            if (frame_fire && cp_frame_last && kind != jsw_pkg::JSW_JOB_RECEIVE) begin
                xdone <= 1'b1;
            end else if (data_start && kind != jsw_pkg::JSW_JOB_RECEIVE) begin
                xdone <= 1'b0;
            end else if (wr_status && !wr_data[`JSW_BIT_XDONE]) begin
                xdone <= 1'b0;
            end
            if (frame_fire && cp_frame_last && kind == jsw_pkg::JSW_JOB_RECEIVE) begin
                adone <= 1'b1;
            end else if (data_start && kind == jsw_pkg::JSW_JOB_RECEIVE) begin
                adone <= 1'b0;
            end else if (wr_status && !wr_data[`JSW_BIT_ADONE]) begin
                adone <= 1'b0;
            end
        end
    end

    // length word: cleared at each new job, then accumulates
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            length      <= 16'h0000;
            first_frame <= 1'b0;
        end else if (retrigger) begin
            length      <= 16'h0000;
            first_frame <= 1'b1;
        end else if (frame_fire) begin
            length      <= next_length;
            first_frame <= 1'b0;
        end
    end

    // dynamic buffer pool; one buffer taken per high-priority job, returned only by a control write with bit 0 set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bufs_free <= 6'(BUF_COUNT);
        end else if (retrigger && job_hi_job_priority_class && !no_buffer) begin
            bufs_free <= bufs_free - 6'h01;
        end else if (wr_control && wr_data[0] && bufs_free != 6'(BUF_COUNT)) begin
            bufs_free <= bufs_free + 6'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            job_taken           <= 1'b0;
            job_refused         <= 1'b0;
            cp_job_issue        <= 1'b0;
            cp_job_kind         <= 2'h0;
            cp_frame_accept     <= 1'b0;
            cp_disable_error    <= 1'b0;
            cp_recv_handshake   <= 1'b0;
            job_status_word     <= `JSW_RST_STATUS;
            job_transfer_length <= 16'h0000;
        end else begin
            job_taken         <= retrigger && !no_buffer;
            job_refused       <= job_req && !(retrigger && !no_buffer);
            cp_job_issue      <= retrigger && !no_buffer;
            cp_job_kind       <= job_kind;
            cp_frame_accept   <= frame_fire;
            cp_disable_error  <= (state == jsw_pkg::JSW_XFER) && cp_frame_valid &&
                                 disable_data && first_frame;
            cp_recv_handshake <= hsk && (state == jsw_pkg::JSW_WAIT_ACK) &&
                                 kind == jsw_pkg::JSW_JOB_RECEIVE;
            job_status_word   <= {4'h0, err_num, disable_data, adone, xdone, xact,
                                  done_err, done_ok, active, hsk};
            job_transfer_length <= length;
        end
    end
endmodule // jsw_job_status

// ### inc/jsw_regs.svh
// Function
// - job status bits in nibble bits 0..3
// - data management nibble; disable bit blocks transfer
// - error nibble valid only with error bit
// - top nibble reserved, reads zero
// - handshake-possible bit follows delete status
// - receive handshake only while handshake-possible set
// - job-active set on issue, cleared on ack
// - no new job while previous active
// - ok bit set on success, cleared on retrigger
// - error bit plus cause; cleared on retrigger
// - transfer-active set at start, cleared last frame
// - transfer-completed set on send done, cleared new
// - acceptance-completed set on receive done, cleared new
// - disable bit set: no data, report error
// - processor error identifier copied to error nibble
// - length word is current plus already transferred
// - length word overwritten at each new job
// - on completion length holds current length
// - on error length holds amount before error
// - error zero with error bit: connection established
// - error seven when buffer pool exhausted
`ifndef JSW_REGS_SVH
`define JSW_REGS_SVH
`define JSW_OFF_STATUS      12'h000
`define JSW_OFF_LENGTH      12'h004
`define JSW_OFF_CONTROL     12'h008
`define JSW_OFF_BUFPOOL     12'h00C
`define JSW_BIT_HSK         0
`define JSW_BIT_ACTIVE      1
`define JSW_BIT_OK          2
`define JSW_BIT_ERR         3
`define JSW_BIT_XACT        4
`define JSW_BIT_XDONE       5
`define JSW_BIT_ADONE       6
`define JSW_BIT_DISABLE     7
`define JSW_ERR_LSB         8
`define JSW_RST_STATUS      16'h0000
`define JSW_ERR_CONNECTED   4'h0
`define JSW_ERR_NO_BUFFER   4'h7
`define JSW_ERR_DISABLED    4'h2
`define JSW_BUF_COUNT       48
`define JSW_BUF_BYTES       128
`endif

// ### inc/jsw_pkg.sv
package jsw_pkg;
    typedef enum logic [1:0] {
        JSW_JOB_NONE,
        JSW_JOB_SEND,
        JSW_JOB_RECEIVE,
        JSW_JOB_FETCH
    } jsw_job_type;

    typedef enum {
        JSW_IDLE,
        JSW_WAIT_ACK,
        JSW_XFER
    } jsw_state_type;
endpackage

// ### hdl/jsw_apb_slave.sv
`timescale 1ns/1ns
`include "jsw_regs.svh"
module jsw_apb_slave (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [15:0] status_word,
    input  wire logic [15:0] length_word,
    input  wire logic [5:0]  bufs_free,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             wr_status,
    output logic             wr_control,
    output logic      [15:0] wr_data
);
    logic        setup;
    logic        mapped;
    logic [31:0] next_prdata;

    assign setup = psel && !penable;
    assign mapped = (paddr == `JSW_OFF_STATUS) || (paddr == `JSW_OFF_LENGTH) ||
                    (paddr == `JSW_OFF_CONTROL) || (paddr == `JSW_OFF_BUFPOOL);

    always_comb begin
        next_prdata = 32'h00000000;
        case (paddr)
            `JSW_OFF_STATUS:  next_prdata = {16'h0000, status_word};
            `JSW_OFF_LENGTH:  next_prdata = {16'h0000, length_word};
            `JSW_OFF_BUFPOOL: next_prdata = {26'h0000000, bufs_free};
            default:          next_prdata = 32'h00000000;
        endcase
    end

    // no wait state: answer registered in the cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            prdata     <= 32'h00000000;
            wr_status  <= 1'b0;
            wr_control <= 1'b0;
            wr_data    <= 16'h0000;
        end else begin
            pready     <= setup;
            pslverr    <= setup && !mapped;
            prdata     <= (setup && !pwrite) ? next_prdata : 32'h00000000;
            wr_status  <= setup && pwrite && (paddr == `JSW_OFF_STATUS);
            wr_control <= setup && pwrite && (paddr == `JSW_OFF_CONTROL);
            wr_data    <= pwdata[15:0];
        end
    end
endmodule // jsw_apb_slave

// ### dv/jsw_job_status_properties.sv
`timescale 1ns/1ns
module jsw_job_status_properties #(
    parameter int BUF_COUNT = 48
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        job_taken,
    input wire logic        cp_job_issue,
    input wire logic        cp_delete,
    input wire logic        cp_frame_accept,
    input wire logic        cp_disable_error,
    input wire logic        cp_recv_handshake,
    input wire logic [15:0] job_status_word
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // delete held long enough for the bit and its mirror to settle
    sequence s_del_hi;
        cp_delete[*5];
    endsequence
    sequence s_del_lo;
        !cp_delete[*5];
    endsequence
    a_top_reserved: assert property (job_status_word[15:12] == 4'h0)
        else $error("reserved nibble not zero");
    a_hsk_cleared: assert property (s_del_hi |-> !job_status_word[0])
        else $error("handshake bit set while delete held");
    a_hsk_set: assert property (s_del_lo |-> job_status_word[0])
        else $error("handshake bit clear while delete low");
    a_recv_gated: assert property (s_del_hi |-> !cp_recv_handshake)
        else $error("receive handshake without handshake bit");
    a_issue_active: assert property (cp_job_issue |-> ##[1:3] job_status_word[1])
        else $error("active bit not set after issue");
    a_issue_taken: assert property (cp_job_issue |-> job_taken)
        else $error("issue without taken pulse");
    a_no_overlap: assert property (job_status_word[1] |-> !cp_job_issue)
        else $error("new job issued while active");
    a_take_clears: assert property (job_taken |-> ##[1:2] job_status_word[3:2] == 2'b00)
        else $error("completion bits not cleared on new job");
    a_disable_blocks: assert property (cp_disable_error |-> !cp_frame_accept)
        else $error("frame accepted while disabled");
endmodule // jsw_job_status_properties
bind jsw_job_status jsw_job_status_properties #(.BUF_COUNT(BUF_COUNT)) i_jsw_job_status_properties (
    .pclk, .presetn, .job_taken, .cp_job_issue, .cp_delete, .cp_frame_accept,
    .cp_disable_error, .cp_recv_handshake, .job_status_word);

// ### dv/jsw_cp_model.sv
`timescale 1ns/1ns
module jsw_cp_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        cp_job_issue,
    input  wire logic        cfg_err,
    input  wire logic [3:0]  cfg_id,
    input  wire logic [3:0]  cfg_delay,
    input  wire logic [3:0]  cfg_frames,
    input  wire logic [15:0] cfg_len,
    output logic             cp_ack,
    output logic             cp_ack_error,
    output logic [3:0]       cp_error_id,
    output logic             cp_frame_valid,
    output logic [15:0]      cp_frame_len,
    output logic             cp_frame_last
);
    initial begin
        cp_ack = 1'b0;
        cp_ack_error = 1'b0;
        cp_error_id = 4'h0;
        cp_frame_valid = 1'b0;
        cp_frame_len = 16'h0000;
        cp_frame_last = 1'b0;
        forever begin
            @(posedge pclk);
            // error id and frame length toggle while idle so stale values never look valid
            cp_error_id <= ~cp_error_id;
            cp_frame_len <= ~cp_frame_len;
            if (presetn && cp_job_issue) begin
                repeat (cfg_delay) @(posedge pclk);
                cp_ack <= 1'b1;
                cp_ack_error <= cfg_err;
                cp_error_id <= cfg_id;
                @(posedge pclk);
                cp_ack <= 1'b0;
                for (int i = 0; i < cfg_frames && !cfg_err; i++) begin
                    @(posedge pclk);
                    cp_frame_valid <= 1'b1;
                    cp_frame_len <= cfg_len;
                    cp_frame_last <= (i == cfg_frames - 1);
                    @(posedge pclk);
                    cp_frame_valid <= 1'b0;
                    cp_frame_len <= ~cfg_len;
                end
            end
        end
    end
endmodule // jsw_cp_model

// ### dv/tb_jsw_job_status.sv
`timescale 1ns/1ns
`include "jsw_regs.svh"
module tb_jsw_job_status;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        job_req, job_hi_job_priority_class, job_taken, job_refused, cp_job_issue;
    logic [1:0]  job_kind, cp_job_kind;
    logic        cp_ack, cp_ack_error, cp_delete, cp_connected, cfg_err;
    logic        cp_frame_valid, cp_frame_last, cp_frame_accept, cp_disable_error;
    logic        cp_recv_handshake;
    logic [3:0]  cp_error_id, cfg_id, cfg_delay, cfg_frames;
    logic [15:0] cp_frame_len, cfg_len, job_status_word, job_transfer_length;
    int          fail_count, samples_checked;

    jsw_job_status #(.BUF_COUNT(2)) i_jsw_job_status (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .job_req, .job_kind,
        .job_hi_job_priority_class, .job_taken, .job_refused, .cp_job_issue, .cp_job_kind, .cp_ack,
        .cp_ack_error, .cp_error_id, .cp_delete, .cp_connected, .cp_frame_valid,
        .cp_frame_len, .cp_frame_last, .cp_frame_accept, .cp_disable_error,
        .cp_recv_handshake, .job_status_word, .job_transfer_length);
    jsw_cp_model i_jsw_cp_model (.pclk, .presetn, .cp_job_issue, .cfg_err, .cfg_id,
        .cfg_delay, .cfg_frames, .cfg_len, .cp_ack, .cp_ack_error, .cp_error_id,
        .cp_frame_valid, .cp_frame_len, .cp_frame_last);

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wait_hi(ref logic s, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (s !== 1'b1 && n < lim);
        if (s !== 1'b1) begin
            fail_count++;
            results();
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        wait_hi(pready, 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, xe});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, 32'h0);
    endtask
    task automatic job(input logic [1:0] k, input logic hp);
        job_kind <= k;
        job_hi_job_priority_class <= hp;
        job_req <= 1'b1;
        wait_hi(job_taken, 50);
        chk({30'h0, cp_job_kind}, {30'h0, k});
        job_req <= 1'b0;
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        // let the clear from the new job reach the mirror first
        repeat (3) @(posedge pclk);
        while (job_status_word[3:2] === 2'b00 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        if (job_status_word[3:2] === 2'b00) begin
            fail_count++;
            results();
        end
        repeat (2) @(posedge pclk);
    endtask

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, job_req, job_hi_job_priority_class, cp_connected} = '0;
        {paddr, pwdata, job_kind, cfg_err, cfg_id, cfg_frames, cfg_len} = '0;
        cp_delete = 1'b1;
        cfg_delay = 4'h8;
        fail_count = 0;
        samples_checked = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`JSW_OFF_STATUS, 32'h0, 1'b0);
        rd(`JSW_OFF_LENGTH, 32'h0, 1'b0);
        rd(`JSW_OFF_BUFPOOL, 32'h2, 1'b0);
        rd(12'h010, 32'h0, 1'b1);
        cp_delete <= 1'b0;
        repeat (8) @(posedge pclk);
        rd(`JSW_OFF_STATUS, 32'h1, 1'b0);
        cp_connected <= 1'b1;
        repeat (4) @(posedge pclk);
        rd(`JSW_OFF_STATUS, 32'h9, 1'b0);
        $display("test reset and connect done");
        cfg_err <= 1'b1;
        cfg_id <= 4'h9;
        job(2'd1, 1'b0);
        rd(`JSW_OFF_STATUS, 32'h3, 1'b0);
        job_req <= 1'b1;
        @(posedge pclk);
        job_req <= 1'b0;
        wait_hi(job_refused, 5);
        wait_done();
        rd(`JSW_OFF_STATUS, 32'h0909, 1'b0);
        rd(`JSW_OFF_LENGTH, 32'h0, 1'b0);
        $display("test error job done");
        cfg_err <= 1'b0;
        cfg_delay <= 4'h4;
        cfg_frames <= 4'h2;
        cfg_len <= 16'h0010;
        for (int k = 1; k < 4; k++) begin
            job(k[1:0], k < 3);
            @(posedge pclk);
            chk({31'h0, cp_recv_handshake}, {31'h0, k == 2});
            wait_done();
            chk({28'h0, job_status_word[3:0]}, 32'h5);
            chk({16'h0, job_transfer_length}, 32'h20);
            if (k < 3)
                chk({25'h0, job_status_word[6:0]}, k == 1 ? 32'h25 : 32'h45);
            chk({31'h0, job_status_word[4]}, 32'h0);
            wr(`JSW_OFF_STATUS, 32'h0000F000);
            // error nibble keeps the earlier cause; meaningless while bit 3 is clear
            rd(`JSW_OFF_STATUS, 32'h0905, 1'b0);
        end
        $display("test job kinds done");
        rd(`JSW_OFF_BUFPOOL, 32'h0, 1'b0);
        job_kind <= 2'd1;
        job_hi_job_priority_class <= 1'b1;
        job_req <= 1'b1;
        @(posedge pclk);
        job_req <= 1'b0;
        wait_done();
        rd(`JSW_OFF_STATUS, 32'h0709, 1'b0);
        wr(`JSW_OFF_CONTROL, 32'h1);
        rd(`JSW_OFF_BUFPOOL, 32'h1, 1'b0);
        $display("test buffer pool done");
        cfg_frames <= 4'h1;
        wr(`JSW_OFF_STATUS, 32'h80);
        job(2'd1, 1'b0);
        wait_hi(cp_disable_error, 40);
        wait_done();
        rd(`JSW_OFF_STATUS, 32'h0289, 1'b0);
        wr(`JSW_OFF_STATUS, 32'h0);
        $display("test disable done");
        results();
    end
endmodule // tb_jsw_job_status
